// ==== rtl/timer16_consts.svh ====
// Offsets, field positions, reset values and top values of the 16-bit timer
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

`define T16_OFS_CTRL_A      8'h80
`define T16_OFS_CTRL_B      8'h81
`define T16_OFS_FORCE       8'h82
`define T16_OFS_COUNT_LO    8'h84
`define T16_OFS_COUNT_HI    8'h85
`define T16_OFS_CAPTURE_LO  8'h86
`define T16_OFS_CAPTURE_HI  8'h87
`define T16_OFS_CMP_A_LO    8'h88
`define T16_OFS_CMP_A_HI    8'h89
`define T16_OFS_CMP_B_LO    8'h8a
`define T16_OFS_CMP_B_HI    8'h8b

`define T16_RST_BYTE        8'h00
`define T16_RST_WORD        16'h0000

`define T16_CTRL_A_COM_A_HI 7
`define T16_CTRL_A_COM_A_LO 6
`define T16_CTRL_A_COM_B_HI 5
`define T16_CTRL_A_COM_B_LO 4
`define T16_CTRL_B_EDGE     6
`define T16_CTRL_B_WAVE_HI  4
`define T16_CTRL_B_WAVE_LO  3
`define T16_CTRL_B_CS_HI    2
`define T16_CTRL_B_CS_LO    0
`define T16_FORCE_A_BIT     7
`define T16_FORCE_B_BIT     6

`define T16_TOP_MAX         16'hffff
`define T16_TOP_8BIT        16'h00ff
`define T16_TOP_9BIT        16'h01ff
`define T16_TOP_10BIT       16'h03ff
`define T16_PRESCALE_WIDTH  10

`endif

// ==== rtl/timer16_pkg.sv ====
// Types shared by the 16-bit timer modules
package timer16_pkg;

	typedef enum logic [2:0]
	{
		CLK_STOP     = 3'h0,
		CLK_DIV1     = 3'h1,
		CLK_DIV8     = 3'h2,
		CLK_DIV64    = 3'h3,
		CLK_DIV256   = 3'h4,
		CLK_DIV1024  = 3'h5,
		CLK_EXT_FALL = 3'h6,
		CLK_EXT_RISE = 3'h7
	} clock_sel_type;

	typedef enum logic [1:0]
	{
		COM_OFF    = 2'h0,
		COM_TOGGLE = 2'h1,
		COM_CLEAR  = 2'h2,
		COM_SET    = 2'h3
	} compare_output_mode_type;

	typedef enum logic [1:0]
	{
		KIND_NON_PWM   = 2'h0,
		KIND_FAST      = 2'h1,
		KIND_PHASE     = 2'h2
	} wave_kind_type;

endpackage

// ==== rtl/timer16_clk_if.sv ====
// Clock-select request and count tick between timer core and clock source
interface timer16_clk_if;
	timer16_pkg::clock_sel_type clock_sel;
	logic                       external_count_pin;
	logic                       tick;

	modport source
	(
		input  clock_sel,
		input  external_count_pin,
		output tick
	);

	modport core
	(
		output clock_sel,
		output external_count_pin,
		input  tick
	);
endinterface

// ==== rtl/timer16_clock_source.sv ====
// Free-running prescaler, external pin edge detector and count clock select
`include "timer16_consts.svh"

module timer16_clock_source
(
	input  wire logic     mclk_i,
	input  wire logic     resetn_i,
	input  wire logic     ce_i,
	timer16_clk_if.source clk_if
);

	logic [`T16_PRESCALE_WIDTH-1:0] presc_r;
	logic [`T16_PRESCALE_WIDTH-1:0] presc_nxt;
	logic                           sync1_r;
	logic                           sync1_nxt;
	logic                           sync2_r;
	logic                           sync2_nxt;
	logic                           prev_r;
	logic                           prev_nxt;
	logic                           tick_r;
	logic                           tick_nxt;

	assign clk_if.tick = tick_r;

	always_comb
	begin
		// Prescaler runs regardless of selection, so first prescaled tick may come early
		presc_nxt = presc_r + {{(`T16_PRESCALE_WIDTH-1){1'b0}}, 1'b1};
		sync1_nxt = clk_if.external_count_pin;
		sync2_nxt = sync1_r;
		prev_nxt  = sync2_r;
		unique case (clk_if.clock_sel)
			timer16_pkg::CLK_STOP:     tick_nxt = 1'b0;
			timer16_pkg::CLK_DIV1:     tick_nxt = 1'b1;
			timer16_pkg::CLK_DIV8:     tick_nxt = &presc_r[2:0];
			timer16_pkg::CLK_DIV64:    tick_nxt = &presc_r[5:0];
			timer16_pkg::CLK_DIV256:   tick_nxt = &presc_r[7:0];
			timer16_pkg::CLK_DIV1024:  tick_nxt = &presc_r[9:0];
			timer16_pkg::CLK_EXT_FALL: tick_nxt = prev_r & ~sync2_r;
			timer16_pkg::CLK_EXT_RISE: tick_nxt = ~prev_r & sync2_r;
		endcase
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			presc_r <= '0;
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r  <= 1'b0;
			tick_r  <= 1'b0;
		end
		else if (ce_i)
		begin
			presc_r <= presc_nxt;
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			prev_r  <= prev_nxt;
			tick_r  <= tick_nxt;
		end
	end

endmodule

// ==== rtl/timer16_regs.sv ====
// 16-bit timer core: byte register file, counter, compare, capture, waveforms
//
// Behaviour
// - Three low control-B bits select count clock
// - Selection zero gives no clock, counter stops
// - Codes 1-5: undivided, /8, /64, /256, /1024
// - Code 6 external falling, 7 rising edge
// - Force bits act only in non-PWM modes
// - Force applies match per current output mode
// - Force: no flag, no clear-on-match reset
// - Force bits are strobes, read zero
// - Low byte at base, high at base+1
// - High byte goes through 8-bit latch
// - One latch shared by all 16-bit registers
// - Counter fully readable and writable by processor
// - Counter write blocks matches next timer clock
// - Capture loads counter on pin or comparator
// - Capture register can be counter top
// - Compare registers matched continuously, drive outputs
// - Force, counter, capture, compares reset zero
// - Match flag set cycle after equality
// - Forced strobe never sets match flag
`include "timer16_consts.svh"

module timer16_regs
(
	input  wire logic       mclk_i,
	input  wire logic       resetn_i,
	input  wire logic       ce_i,
	input  wire logic [7:0] addr_i,
	input  wire logic       wr_en_i,
	input  wire logic       rd_en_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       external_count_pin_i,
	input  wire logic       capture_input_pin_i,
	input  wire logic       comparator_out_i,
	input  wire logic       capture_from_comparator_i,
	output logic      [7:0] rdata_o,
	output logic            wave_out_a_o,
	output logic            wave_out_b_o,
	output logic            compare_a_flag_o,
	output logic            compare_b_flag_o,
	output logic            capture_flag_o
);

	timer16_clk_if clk_if ();

	logic [7:0]  ctrl_a_r;
	logic [7:0]  ctrl_a_nxt;
	logic [7:0]  ctrl_b_r;
	logic [7:0]  ctrl_b_nxt;
	logic [7:0]  temp_r;
	logic [7:0]  temp_nxt;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic [15:0] capture_r;
	logic [15:0] capture_nxt;
	logic [15:0] cmp_a_r;
	logic [15:0] cmp_a_nxt;
	logic [15:0] cmp_b_r;
	logic [15:0] cmp_b_nxt;
	logic        down_r;
	logic        down_nxt;
	logic        block_r;
	logic        block_nxt;
	logic [7:0]  rdata_nxt;
	logic        wave_a_nxt;
	logic        wave_b_nxt;
	logic        flag_a_nxt;
	logic        flag_b_nxt;
	logic        cap_flag_nxt;
	logic        cap_s1_r;
	logic        cap_s2_r;
	logic        cap_prev_r;
	logic        cap_src;
	logic        cap_edge;

	logic [3:0]                          wave_mode_field;
	logic [15:0]                         top;
	timer16_pkg::wave_kind_type          kind;
	timer16_pkg::compare_output_mode_type com_a;
	timer16_pkg::compare_output_mode_type com_b;
	logic                                match_a;
	logic                                match_b;
	logic                                at_top;
	logic                                wr;
	logic                                force_a;
	logic                                force_b;

	timer16_clock_source u_clock_source
	(
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.ce_i     (ce_i),
		.clk_if   (clk_if)
	);

	// Counter top for the current waveform mode
	function automatic logic [15:0] top_of
	(
		input logic [3:0]  mode,
		input logic [15:0] cmp_a,
		input logic [15:0] icr
	);
		unique case (mode)
			4'h1, 4'h5:             top_of = `T16_TOP_8BIT;
			4'h2, 4'h6:             top_of = `T16_TOP_9BIT;
			4'h3, 4'h7:             top_of = `T16_TOP_10BIT;
			4'h4, 4'h9, 4'hb, 4'hf: top_of = cmp_a;
			4'h8, 4'ha, 4'hc, 4'he: top_of = icr;
			default:                top_of = `T16_TOP_MAX;
		endcase
	endfunction

	function automatic timer16_pkg::wave_kind_type kind_of
	(
		input logic [3:0] mode
	);
		unique case (mode)
			4'h0, 4'h4, 4'hc, 4'hd:       kind_of = timer16_pkg::KIND_NON_PWM;
			4'h5, 4'h6, 4'h7, 4'he, 4'hf: kind_of = timer16_pkg::KIND_FAST;
			default:                      kind_of = timer16_pkg::KIND_PHASE;
		endcase
	endfunction

	function automatic logic icr_is_top
	(
		input logic [3:0] mode
	);
		icr_is_top = (mode == 4'h8) || (mode == 4'ha) || (mode == 4'hc) || (mode == 4'he);
	endfunction

	// Next waveform pin level on a match; toggle in PWM only where allowed
	function automatic logic wave_on_match
	(
		input logic                                 cur,
		input timer16_pkg::compare_output_mode_type com,
		input timer16_pkg::wave_kind_type           knd,
		input logic                                 down,
		input logic                                 may_toggle
	);
		logic up_level;
		up_level = (com == timer16_pkg::COM_SET);
		unique case (com)
			timer16_pkg::COM_OFF:    wave_on_match = cur;
			timer16_pkg::COM_TOGGLE:
				wave_on_match = (knd == timer16_pkg::KIND_NON_PWM || may_toggle) ? ~cur : cur;
			default:
				if (knd == timer16_pkg::KIND_PHASE && down)
					wave_on_match = ~up_level;
				else
					wave_on_match = up_level;
		endcase
	endfunction

	// Fast PWM restores the pin opposite to its match level at the wrap
	function automatic logic wave_on_wrap
	(
		input logic                                 cur,
		input timer16_pkg::compare_output_mode_type com
	);
		unique case (com)
			timer16_pkg::COM_CLEAR: wave_on_wrap = 1'b1;
			timer16_pkg::COM_SET:   wave_on_wrap = 1'b0;
			default:                wave_on_wrap = cur;
		endcase
	endfunction

	// Capture pin is asynchronous: two flops before any logic
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cap_s1_r   <= 1'b0;
			cap_s2_r   <= 1'b0;
			cap_prev_r <= 1'b0;
		end
		else if (ce_i)
		begin
			cap_s1_r   <= capture_input_pin_i;
			cap_s2_r   <= cap_s1_r;
			cap_prev_r <= cap_src;
		end
	end

	always_comb
	begin
		wave_mode_field = {ctrl_b_r[`T16_CTRL_B_WAVE_HI:`T16_CTRL_B_WAVE_LO], ctrl_a_r[1:0]};
		top      = top_of(wave_mode_field, cmp_a_r, capture_r);
		kind     = kind_of(wave_mode_field);
		com_a    = timer16_pkg::compare_output_mode_type'(
			ctrl_a_r[`T16_CTRL_A_COM_A_HI:`T16_CTRL_A_COM_A_LO]);
		com_b    = timer16_pkg::compare_output_mode_type'(
			ctrl_a_r[`T16_CTRL_A_COM_B_HI:`T16_CTRL_A_COM_B_LO]);
		clk_if.clock_sel = timer16_pkg::clock_sel_type'(
			ctrl_b_r[`T16_CTRL_B_CS_HI:`T16_CTRL_B_CS_LO]);
		clk_if.external_count_pin = external_count_pin_i;
		cap_src  = capture_from_comparator_i ? comparator_out_i : cap_s2_r;
		cap_edge = ctrl_b_r[`T16_CTRL_B_EDGE] ? (cap_src & ~cap_prev_r)
			: (~cap_src & cap_prev_r);
		// Matches are sampled on the timer clock and blocked after a counter write
		match_a  = clk_if.tick && (count_r == cmp_a_r) && !block_r;
		match_b  = clk_if.tick && (count_r == cmp_b_r) && !block_r;
		at_top   = (count_r == top);
		wr       = wr_en_i;
		force_a  = wr && (addr_i == `T16_OFS_FORCE) && wdata_i[`T16_FORCE_A_BIT]
			&& (kind == timer16_pkg::KIND_NON_PWM);
		force_b  = wr && (addr_i == `T16_OFS_FORCE) && wdata_i[`T16_FORCE_B_BIT]
			&& (kind == timer16_pkg::KIND_NON_PWM);
	end

	// Register file and counter
	always_comb
	begin
		ctrl_a_nxt  = ctrl_a_r;
		ctrl_b_nxt  = ctrl_b_r;
		temp_nxt    = temp_r;
		count_nxt   = count_r;
		capture_nxt = capture_r;
		cmp_a_nxt   = cmp_a_r;
		cmp_b_nxt   = cmp_b_r;
		down_nxt    = down_r;
		block_nxt   = block_r;
		rdata_nxt   = rdata_o;
		cap_flag_nxt = 1'b0;

		// Counting; a processor write below takes priority
		if (clk_if.tick)
		begin
			block_nxt = 1'b0;
			if (kind == timer16_pkg::KIND_PHASE)
			begin
				if (down_r && count_r == 16'h0000)
				begin
					down_nxt  = 1'b0;
					count_nxt = 16'h0001;
				end
				else if (!down_r && count_r >= top)
				begin
					down_nxt  = 1'b1;
					count_nxt = count_r - 16'h0001;
				end
				else
					count_nxt = down_r ? count_r - 16'h0001 : count_r + 16'h0001;
			end
			else
			begin
				down_nxt  = 1'b0;
				count_nxt = at_top ? 16'h0000 : count_r + 16'h0001;
			end
			if (icr_is_top(wave_mode_field) && at_top)
				cap_flag_nxt = 1'b1;
		end

		// Input capture is cut off while the capture register is the top
		if (cap_edge && !icr_is_top(wave_mode_field))
		begin
			capture_nxt  = count_r;
			cap_flag_nxt = 1'b1;
		end

		if (rd_en_i)
		begin
			unique case (addr_i)
				`T16_OFS_CTRL_A:     rdata_nxt = ctrl_a_r;
				`T16_OFS_CTRL_B:     rdata_nxt = ctrl_b_r;
				`T16_OFS_FORCE:      rdata_nxt = 8'h00;
				`T16_OFS_COUNT_LO:
				begin
					rdata_nxt = count_r[7:0];
					temp_nxt  = count_r[15:8];
				end
				`T16_OFS_CAPTURE_LO:
				begin
					rdata_nxt = capture_r[7:0];
					temp_nxt  = capture_r[15:8];
				end
				`T16_OFS_CMP_A_LO:
				begin
					rdata_nxt = cmp_a_r[7:0];
					temp_nxt  = cmp_a_r[15:8];
				end
				`T16_OFS_CMP_B_LO:
				begin
					rdata_nxt = cmp_b_r[7:0];
					temp_nxt  = cmp_b_r[15:8];
				end
				`T16_OFS_COUNT_HI, `T16_OFS_CAPTURE_HI,
				`T16_OFS_CMP_A_HI, `T16_OFS_CMP_B_HI:
					rdata_nxt = temp_r;
				default:             rdata_nxt = 8'h00;
			endcase
		end

		// One shared latch: interleaving two registers' accesses corrupts the one whose high byte was latched first
		if (wr)
		begin
			unique case (addr_i)
				`T16_OFS_CTRL_A:     ctrl_a_nxt = wdata_i;
				`T16_OFS_CTRL_B:     ctrl_b_nxt = wdata_i & 8'hdf;
				`T16_OFS_COUNT_LO:
				begin
					count_nxt = {temp_r, wdata_i};
					block_nxt = 1'b1;
				end
				`T16_OFS_CAPTURE_LO: capture_nxt = {temp_r, wdata_i};
				`T16_OFS_CMP_A_LO:   cmp_a_nxt   = {temp_r, wdata_i};
				`T16_OFS_CMP_B_LO:   cmp_b_nxt   = {temp_r, wdata_i};
				`T16_OFS_COUNT_HI, `T16_OFS_CAPTURE_HI,
				`T16_OFS_CMP_A_HI, `T16_OFS_CMP_B_HI:
					temp_nxt = wdata_i;
				default:             ;
			endcase
		end
	end

	// Waveform pins and match flags
	always_comb
	begin
		wave_a_nxt = wave_out_a_o;
		wave_b_nxt = wave_out_b_o;
		if (kind == timer16_pkg::KIND_FAST && clk_if.tick && at_top)
		begin
			wave_a_nxt = wave_on_wrap(wave_out_a_o, com_a);
			wave_b_nxt = wave_on_wrap(wave_out_b_o, com_b);
		end
		if (match_a)
			wave_a_nxt = wave_on_match(wave_out_a_o, com_a, kind, down_r,
				wave_mode_field == 4'h9 || wave_mode_field == 4'hb || wave_mode_field == 4'hf);
		if (match_b)
			wave_b_nxt = wave_on_match(wave_out_b_o, com_b, kind, down_r, 1'b0);
		// Forced match uses the output mode present now, touches nothing else
		if (force_a)
			wave_a_nxt = wave_on_match(wave_out_a_o, com_a, kind, 1'b0, 1'b0);
		if (force_b)
			wave_b_nxt = wave_on_match(wave_out_b_o, com_b, kind, 1'b0, 1'b0);
		flag_a_nxt = match_a;
		flag_b_nxt = match_b;
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ctrl_a_r         <= `T16_RST_BYTE;
			ctrl_b_r         <= `T16_RST_BYTE;
			temp_r           <= `T16_RST_BYTE;
			count_r          <= `T16_RST_WORD;
			capture_r        <= `T16_RST_WORD;
			cmp_a_r          <= `T16_RST_WORD;
			cmp_b_r          <= `T16_RST_WORD;
			down_r           <= 1'b0;
			block_r          <= 1'b0;
			rdata_o          <= `T16_RST_BYTE;
			wave_out_a_o     <= 1'b0;
			wave_out_b_o     <= 1'b0;
			compare_a_flag_o <= 1'b0;
			compare_b_flag_o <= 1'b0;
			capture_flag_o   <= 1'b0;
		end
		else if (ce_i)
		begin
			ctrl_a_r         <= ctrl_a_nxt;
			ctrl_b_r         <= ctrl_b_nxt;
			temp_r           <= temp_nxt;
			count_r          <= count_nxt;
			capture_r        <= capture_nxt;
			cmp_a_r          <= cmp_a_nxt;
			cmp_b_r          <= cmp_b_nxt;
			down_r           <= down_nxt;
			block_r          <= block_nxt;
			rdata_o          <= rdata_nxt;
			wave_out_a_o     <= wave_a_nxt;
			wave_out_b_o     <= wave_b_nxt;
			compare_a_flag_o <= flag_a_nxt;
			compare_b_flag_o <= flag_b_nxt;
			capture_flag_o   <= cap_flag_nxt;
		end
	end

endmodule

// ==== tb/timer16_regs_sva.sv ====
// Concurrent checks on the ports of the 16-bit timer register block
module timer16_regs_sva
(
	input  wire logic       mclk_i,
	input  wire logic       resetn_i,
	input  wire logic       ce_i,
	input  wire logic [7:0] addr_i,
	input  wire logic       wr_en_i,
	input  wire logic       rd_en_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       external_count_pin_i,
	input  wire logic       capture_input_pin_i,
	input  wire logic       comparator_out_i,
	input  wire logic       capture_from_comparator_i,
	input  wire logic [7:0] rdata_o,
	input  wire logic       wave_out_a_o,
	input  wire logic       wave_out_b_o,
	input  wire logic       compare_a_flag_o,
	input  wire logic       compare_b_flag_o,
	input  wire logic       capture_flag_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] ctrl_a_r;
	logic [7:0] ctrl_b_r;
	logic [1:0] stop_r;
	logic [3:0] mode;
	logic       non_pwm;
	logic       force_wr;
	logic       hi_wr;

	// Shadows of the control bytes; idle count saturates so it never wraps
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ctrl_a_r <= 8'h00;
			ctrl_b_r <= 8'h00;
			stop_r   <= 2'h0;
		end
		else if (ce_i)
		begin
			if (wr_en_i && addr_i == 8'h80)
				ctrl_a_r <= wdata_i;
			if (wr_en_i && addr_i == 8'h81)
				ctrl_b_r <= wdata_i;
			if (ctrl_b_r[2:0] != 3'h0)
				stop_r <= 2'h0;
			else if (stop_r != 2'h3)
				stop_r <= stop_r + 2'h1;
		end
	end

	assign mode     = {ctrl_b_r[4:3], ctrl_a_r[1:0]};
	assign non_pwm  = (mode == 4'h0) || (mode == 4'h4) || (mode == 4'hc);
	assign force_wr = wr_en_i && ce_i && addr_i == 8'h82;
	assign hi_wr    = wr_en_i && ce_i && addr_i[0] && addr_i >= 8'h85 && addr_i <= 8'h8b;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	chk_force_read_zero: assert property
		(rd_en_i && ce_i && addr_i == 8'h82 |=> rdata_o == 8'h00)
		else $error("force register read not zero");
	chk_reset_outputs: assert property
		($rose(resetn_i) |-> rdata_o == 8'h00 && !wave_out_a_o && !wave_out_b_o)
		else $error("outputs not clear after reset");
	chk_stop_no_match: assert property
		(stop_r == 2'h3 |-> !compare_a_flag_o && !compare_b_flag_o)
		else $error("match flag while clock stopped");
	chk_force_a_apply: assert property
		(force_wr && wdata_i[7] && non_pwm && stop_r == 2'h3 && ctrl_a_r[7:6] == 2'h1
			|=> wave_out_a_o != $past(wave_out_a_o))
		else $error("forced match did not toggle output a");
	chk_force_b_apply: assert property
		(force_wr && wdata_i[6] && non_pwm && stop_r == 2'h3 && ctrl_a_r[5:4] == 2'h1
			|=> wave_out_b_o != $past(wave_out_b_o))
		else $error("forced match did not toggle output b");
	chk_force_pwm_ignored: assert property
		(force_wr && !non_pwm && mode != 4'hd && stop_r == 2'h3
			|=> $stable(wave_out_a_o) && $stable(wave_out_b_o))
		else $error("forced match acted in pwm mode");
	chk_shared_latch: assert property
		(hi_wr ##1 (!wr_en_i && !rd_en_i) ##1 (rd_en_i && ce_i && addr_i == 8'h89 && !wr_en_i)
			|=> rdata_o == $past(wdata_i, 3))
		else $error("high byte read does not return shared latch");
	chk_write_blocks_match: assert property
		(wr_en_i && ce_i && addr_i == 8'h84 && ctrl_b_r[2:0] == 3'h1
			|-> ##2 !compare_a_flag_o && !compare_b_flag_o)
		else $error("match flagged right after counter write");
endmodule

bind timer16_regs timer16_regs_sva chk
(
	.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i), .addr_i(addr_i),
	.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i),
	.external_count_pin_i(external_count_pin_i), .capture_input_pin_i(capture_input_pin_i),
	.comparator_out_i(comparator_out_i), .capture_from_comparator_i(capture_from_comparator_i),
	.rdata_o(rdata_o), .wave_out_a_o(wave_out_a_o), .wave_out_b_o(wave_out_b_o),
	.compare_a_flag_o(compare_a_flag_o), .compare_b_flag_o(compare_b_flag_o),
	.capture_flag_o(capture_flag_o)
);

// ==== tb/timer16_pin_model.sv ====
// Far-side model of the external count pin and the capture pin
module timer16_pin_model
(
	input  wire logic mclk_i,
	output logic      external_count_pin_o,
	output logic      capture_input_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		external_count_pin_o = 1'b0;
		capture_input_pin_o  = 1'b0;
	end

	// Levels held several cycles so the synchroniser cannot miss an edge
	task automatic count_pulses(input int n);
		repeat (n)
		begin
			@(negedge mclk_i);
			external_count_pin_o = 1'b1;
			repeat (4) @(negedge mclk_i);
			external_count_pin_o = 1'b0;
			repeat (3) @(negedge mclk_i);
		end
	endtask

	task automatic capture_edge();
		@(negedge mclk_i);
		capture_input_pin_o = 1'b1;
		repeat (4) @(negedge mclk_i);
		capture_input_pin_o = 1'b0;
	endtask
endmodule

// ==== tb/timer16_clock_select_and_registers_bench.sv ====
// Self-checking bench for the 16-bit timer register block
module timer16_clock_select_and_registers_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk_i  = 1'b0;
	logic        resetn_i = 1'b0;
	logic [7:0]  addr_i  = 8'h00;
	logic        wr_en_i = 1'b0;
	logic        rd_en_i = 1'b0;
	logic [7:0]  wdata_i = 8'h00;
	logic        cmp_out = 1'b0;
	logic        cmp_sel = 1'b0;
	logic        ext_pin;
	logic        cap_pin;
	logic [7:0]  rdata_o;
	logic        wave_a;
	logic        wave_b;
	logic        flag_a;
	logic        flag_b;
	int          errors = 0;
	int          total_checks = 0;
	int          hits_a = 0;
	int          hits_b = 0;
	logic        cap_flag;
	int          hits_c = 0;

	timer16_regs uut
	(
		.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(1'b1), .addr_i(addr_i),
		.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i),
		.external_count_pin_i(ext_pin), .capture_input_pin_i(cap_pin),
		.comparator_out_i(cmp_out), .capture_from_comparator_i(cmp_sel),
		.rdata_o(rdata_o), .wave_out_a_o(wave_a), .wave_out_b_o(wave_b),
		.compare_a_flag_o(flag_a), .compare_b_flag_o(flag_b), .capture_flag_o(cap_flag)
	);

	timer16_pin_model pins
	(
		.mclk_i(mclk_i), .external_count_pin_o(ext_pin), .capture_input_pin_o(cap_pin)
	);

	initial
	begin
		forever #20 mclk_i = ~mclk_i;
	end

	// Pulses counted mid-cycle, where they are settled
	always @(negedge mclk_i)
	begin
		if (flag_a === 1'b1)
			hits_a++;
		if (flag_b === 1'b1)
			hits_b++;
		if (cap_flag === 1'b1)
			hits_c++;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		addr_i = a;
		wdata_i = d;
		wr_en_i = 1'b1;
		@(negedge mclk_i);
		wr_en_i = 1'b0;
	endtask

	task automatic rd8(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk_i);
		addr_i = a;
		rd_en_i = 1'b1;
		@(negedge mclk_i);
		rd_en_i = 1'b0;
		d = rdata_o;
	endtask

	// High byte first on write, low byte first on read
	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		wr8(a + 8'h01, d[15:8]);
		wr8(a, d[7:0]);
	endtask

	task automatic rd16(input logic [7:0] a, output logic [15:0] d);
		rd8(a, d[7:0]);
		rd8(a + 8'h01, d[15:8]);
	endtask

	initial
	begin
		repeat (60000) @(posedge mclk_i);
		errors++;
		summarize();
	end

	initial
	begin
		logic [15:0] v;
		logic [7:0]  b;
		int          n;
		int          dv [5];
		dv = '{1, 8, 64, 256, 1024};
		repeat (20) @(negedge mclk_i);
		resetn_i = 1'b1;
		rd8(8'h82, b);
		check(16'(b), 16'h0000);
		for (int a = 8'h84; a <= 8'h8a; a += 2)
		begin
			rd16(8'(a), v);
			check(v, 16'h0000);
			wr16(8'(a), 16'h1234 + 16'(a));
			rd16(8'(a), v);
			check(v, 16'h1234 + 16'(a));
		end
		repeat (40) @(negedge mclk_i);
		rd16(8'h84, v);
		check(v, 16'h12b8);
		wr8(8'h85, 8'hab);
		rd8(8'h89, b);
		check(16'(b), 16'h00ab);
		wr8(8'h8a, 8'hcd);
		rd16(8'h8a, v);
		check(v, 16'habcd);
		wr8(8'h80, 8'h50);
		wr8(8'h82, 8'hc0);
		rd8(8'h82, b);
		check(16'(b), 16'h0000);
		check(16'({wave_a, wave_b}), 16'h0003);
		wr8(8'h80, 8'h51);
		wr8(8'h82, 8'hc0);
		check(16'({wave_a, wave_b}), 16'h0003);
		wr8(8'h80, 8'h50);
		wr8(8'h81, 8'h08);
		wr8(8'h82, 8'h80);
		check(16'({wave_a, wave_b}), 16'h0001);
		rd16(8'h84, v);
		check(v, 16'h12b8);
		check(16'(hits_a + hits_b), 16'h0000);
		// Counter only rewritten while stopped
		for (int i = 0; i < 5; i++)
		begin
			wr8(8'h81, 8'h00);
			wr16(8'h84, 16'h0000);
			wr8(8'h81, 8'(i + 1));
			repeat (16 * dv[i]) @(negedge mclk_i);
			wr8(8'h81, 8'h00);
			rd16(8'h84, v);
			check(16'(v >= 16'd15 && v <= 16'd18), 16'h0001);
		end
		for (int c = 6; c <= 7; c++)
		begin
			wr16(8'h84, 16'h0000);
			wr8(8'h81, 8'(c));
			pins.count_pulses(5);
			repeat (8) @(negedge mclk_i);
			wr8(8'h81, 8'h00);
			rd16(8'h84, v);
			check(v, 16'h0005);
		end
		wr16(8'h88, 16'h0020);
		wr16(8'h84, 16'h0000);
		wr8(8'h80, 8'h40);
		hits_a = 0;
		wr8(8'h81, 8'h01);
		n = 0;
		while (flag_a !== 1'b1 && n < 100)
		begin
			@(negedge mclk_i);
			n++;
		end
		check(16'(n >= 32 && n <= 36), 16'h0001);
		repeat (10) @(negedge mclk_i);
		check(16'(hits_a), 16'h0001);
		check(16'(wave_a), 16'h0001);
		wr16(8'h8a, 16'h0100);
		hits_b = 0;
		wr16(8'h84, 16'h0100);
		repeat (20) @(negedge mclk_i);
		check(16'(hits_b), 16'h0000);
		wr8(8'h81, 8'h40);
		wr16(8'h84, 16'h2345);
		pins.capture_edge();
		repeat (8) @(negedge mclk_i);
		rd16(8'h86, v);
		check(v, 16'h2345);
		wr16(8'h84, 16'h3456);
		cmp_sel = 1'b1;
		repeat (2) @(negedge mclk_i);
		cmp_out = 1'b1;
		repeat (8) @(negedge mclk_i);
		rd16(8'h86, v);
		check(v, 16'h3456);
		check(16'(hits_c), 16'h0002);
		// Capture register as top: counter wraps early, capture input cut off
		wr16(8'h86, 16'h0009);
		wr16(8'h84, 16'h0000);
		wr8(8'h81, 8'h19);
		repeat (20) @(negedge mclk_i);
		cmp_out = 1'b0;
		repeat (20) @(negedge mclk_i);
		wr8(8'h81, 8'h18);
		rd16(8'h84, v);
		check(16'(v <= 16'h0009), 16'h0001);
		rd16(8'h86, v);
		check(v, 16'h0009);
		summarize();
	end
endmodule
